// [fpcc_ctrl.sv]
// Purpose: Fp context control register, lazy preservation, fp registers
// Assumes: Processor side pulses arrive on aclk, one cycle each
// Notes:   AXI bank select follows the prot non-secure bit; core side uses cur_secure and alloc_info.secure
//
// The register addresses and the AXI4-Lite interface to the registers were left to the implementer.
module fpcc_ctrl
  import fpcc_pkg::*;
#(
  parameter bit HAS_SEC = 1'b1,
  parameter int NSREG   = 32
) (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [3:0]             s_awaddr,
  input  wire logic [2:0]             s_awprot,
  input  wire logic                   s_awvalid,
  output logic                        s_awready,
  input  wire logic [31:0]            s_wdata,
  input  wire logic [3:0]             s_wstrb,
  input  wire logic                   s_wvalid,
  output logic                        s_wready,
  output logic [1:0]                  s_bresp,
  output logic                        s_bvalid,
  input  wire logic                   s_bready,
  input  wire logic [3:0]             s_araddr,
  input  wire logic [2:0]             s_arprot,
  input  wire logic                   s_arvalid,
  output logic                        s_arready,
  output logic [31:0]                 s_rdata,
  output logic [1:0]                  s_rresp,
  output logic                        s_rvalid,
  input  wire logic                   s_rready,
  input  wire logic                   fp_instr_exec,
  input  wire logic                   cur_secure,
  input  wire logic                   exc_entry,
  input  wire fpcc_pkg::fpcc_alloc_t  alloc_info,
  input  wire logic                   exc_return,
  input  wire logic                   ret_fp_frame,
  input  wire fpcc_pkg::fpcc_rf_req_t rf_req,
  output logic [63:0]                 rf_rd_data,
  output logic [31:0]                 fp_status_control,
  output logic                        context_active_flag,
  output logic                        save_pulse,
  output logic                        restore_pulse,
  output logic                        clear_pulse,
  output logic                        skip_mem,
  output logic                        irq
);
  typedef struct packed {
    logic                  awready;
    logic                  wready;
    logic                  aw_got;
    logic                  w_got;
    logic [3:0]            awaddr;
    logic                  aw_ns;
    logic [31:0]           wdata;
    logic [3:0]            wstrb;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  arready;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
    fpcc_bank_t [1:0]      bank;
    logic                  ctx_act;
    logic                  lazy_bank;
    logic [NEV-1:0]        sts;
    logic [NEV-1:0]        mask;
    logic                  irq;
    logic                  save;
    logic                  restore;
    logic                  clear;
    logic                  skip;
    logic [NSREG-1:0][31:0] sreg;
    logic [31:0]           fp_stat;
    logic [63:0]           rd_data;
  } fpcc_state_t;

  fpcc_state_t st_r;
  fpcc_state_t st_nxt;

  function automatic logic [31:0] pack_bank(fpcc_bank_t b, fpcc_bank_t s);
    logic [31:0] w;
    w = ZERO32;
    w[B_AUTO_EN] = b.auto_en;
    w[B_LAZY_EN] = b.lazy_en;
    w[B_CLRRET]  = b.clr_ret;
    w[B_UF_RDY]  = b.uf_rdy;
    w[B_SPLIM]   = b.splim;
    w[B_BF_RDY]  = b.bf_rdy;
    w[B_THREAD]  = b.thread;
    w[B_LZ_ACT]  = b.lazy_act;
    if (HAS_SEC) begin
      w[B_LSLOCK]  = s.lazy_lock;
      w[B_CLRLOCK] = s.clr_lock;
      w[B_TSEC]    = s.tsec;
    end
    return w;
  endfunction : pack_bank

  always_comb begin
    logic        bi;
    logic        wsel;
    logic        ns;
    logic [31:0] wv;
    logic [NEV-1:0] ev;
    bi     = 1'b0;
    wsel   = 1'b0;
    ns     = 1'b0;
    wv     = ZERO32;
    ev     = '0;
    st_nxt = st_r;
    st_nxt.save    = 1'b0;
    st_nxt.restore = 1'b0;
    st_nxt.clear   = 1'b0;

    // Write address and data, either order
    if (s_awvalid && st_r.awready) begin
      st_nxt.aw_got  = 1'b1;
      st_nxt.awaddr  = s_awaddr;
      st_nxt.aw_ns   = s_awprot[1];
      st_nxt.awready = 1'b0;
    end
    if (s_wvalid && st_r.wready) begin
      st_nxt.w_got  = 1'b1;
      st_nxt.wdata  = s_wdata;
      st_nxt.wstrb  = s_wstrb;
      st_nxt.wready = 1'b0;
    end
    if (st_r.bvalid && s_bready) begin
      st_nxt.bvalid  = 1'b0;
      st_nxt.awready = 1'b1;
      st_nxt.wready  = 1'b1;
    end

    // Register write once both halves held
    if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got  = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = RESP_OK;
      ns = HAS_SEC ? st_r.aw_ns : 1'b0;
      bi = HAS_SEC ? !st_r.aw_ns : 1'b0;
      wv = st_r.wdata;
      unique case (st_r.awaddr)
        OFS_CTRL: begin
          if (st_r.wstrb[3]) begin
            st_nxt.bank[bi].auto_en = wv[B_AUTO_EN];
            if (!(ns && st_r.bank[1].lazy_lock)) begin
              st_nxt.bank[bi].lazy_en = wv[B_LAZY_EN];
            end
            if (!(ns && st_r.bank[1].clr_lock)) begin
              st_nxt.bank[bi].clr_ret = wv[B_CLRRET];
            end
            if (HAS_SEC && !ns) begin
              st_nxt.bank[1].lazy_lock = wv[B_LSLOCK];
              st_nxt.bank[1].clr_lock  = wv[B_CLRLOCK];
              st_nxt.bank[1].tsec      = wv[B_TSEC];
            end
          end
          if (st_r.wstrb[1]) begin
            st_nxt.bank[bi].uf_rdy = wv[B_UF_RDY];
            st_nxt.bank[bi].splim  = wv[B_SPLIM];
          end
          if (st_r.wstrb[0]) begin
            st_nxt.bank[bi].bf_rdy   = wv[B_BF_RDY];
            st_nxt.bank[bi].thread   = wv[B_THREAD];
            st_nxt.bank[bi].lazy_act = wv[B_LZ_ACT];
          end
        end
        OFS_STS: begin
          wsel = st_r.wstrb[0];
        end
        OFS_MASK: begin
          if (st_r.wstrb[0]) begin
            st_nxt.mask = wv[NEV-1:0];
          end
        end
        default: begin
          st_nxt.bresp = RESP_ERR;
        end
      endcase
    end

    // Read channel
    if (st_r.rvalid && s_rready) begin
      st_nxt.rvalid  = 1'b0;
      st_nxt.arready = 1'b1;
    end
    if (s_arvalid && st_r.arready) begin
      st_nxt.arready = 1'b0;
      st_nxt.rvalid  = 1'b1;
      st_nxt.rresp   = RESP_OK;
      bi = HAS_SEC ? !s_arprot[1] : 1'b0;
      unique case (s_araddr)
        OFS_CTRL: st_nxt.rdata = pack_bank(st_r.bank[bi], st_r.bank[1]);
        OFS_STS:  st_nxt.rdata = {{(32-NEV){1'b0}}, st_r.sts};
        OFS_MASK: st_nxt.rdata = {{(32-NEV){1'b0}}, st_r.mask};
        default: begin
          st_nxt.rdata = ZERO32;
          st_nxt.rresp = RESP_ERR;
        end
      endcase
    end

    // Fp instruction activity
    bi = HAS_SEC ? cur_secure : 1'b0;
    if (fp_instr_exec) begin
      if (st_r.bank[bi].auto_en) begin
        st_nxt.ctx_act = 1'b1;
      end
      if (st_r.bank[st_r.lazy_bank].lazy_act) begin
        st_nxt.bank[st_r.lazy_bank].lazy_act = 1'b0;
        st_nxt.save = !st_r.bank[st_r.lazy_bank].splim;
      end
    end

    // Frame allocation on exception entry
    if (exc_entry && st_r.ctx_act) begin
      bi = HAS_SEC ? alloc_info.secure : 1'b0;
      st_nxt.lazy_bank        = bi;
      st_nxt.bank[bi].uf_rdy  = alloc_info.uf_rdy;
      st_nxt.bank[bi].bf_rdy  = alloc_info.bf_rdy;
      st_nxt.bank[bi].thread  = alloc_info.thread;
      st_nxt.bank[bi].splim   = alloc_info.splim;
      st_nxt.skip             = alloc_info.splim;
      ev[EV_SPLIM]            = alloc_info.splim;
      if (st_r.bank[bi].lazy_en) begin
        st_nxt.bank[bi].lazy_act = 1'b1;
      end else begin
        st_nxt.save = !alloc_info.splim;
      end
      st_nxt.ctx_act = 1'b0;
    end

    // Exception return and clear of caller-saved state
    if (exc_return) begin
      bi = HAS_SEC ? cur_secure : 1'b0;
      if (st_r.ctx_act && st_r.bank[bi].clr_ret &&
          !st_r.bank[HAS_SEC ? 1 : 0].lazy_act) begin
        st_nxt.clear   = 1'b1;
        st_nxt.fp_stat = ZERO32;
        ev[EV_CLR]   = 1'b1;
        for (int i = 0; i < NSREG / 2; i++) begin
          st_nxt.sreg[i] = ZERO32;
        end
      end
      st_nxt.ctx_act = ret_fp_frame;
      st_nxt.restore = ret_fp_frame &&
                       !st_r.bank[st_r.lazy_bank].lazy_act;
    end

    // Register file, single or double view
    if (rf_req.wr_en) begin
      if (rf_req.wr_dbl) begin
        st_nxt.sreg[{rf_req.wr_idx[3:0], 1'b0}] = rf_req.wr_data[31:0];
        st_nxt.sreg[{rf_req.wr_idx[3:0], 1'b1}] = rf_req.wr_data[63:32];
      end else begin
        st_nxt.sreg[rf_req.wr_idx] = rf_req.wr_data[31:0];
      end
    end
    if (rf_req.rd_dbl) begin
      st_nxt.rd_data = {st_r.sreg[{rf_req.rd_idx[3:0], 1'b1}],
                        st_r.sreg[{rf_req.rd_idx[3:0], 1'b0}]};
    end else begin
      st_nxt.rd_data = {ZERO32, st_r.sreg[rf_req.rd_idx]};
    end

    // Sticky status, set wins over clear
    if (wsel) begin
      st_nxt.sts = st_r.sts & ~wv[NEV-1:0];
    end
    st_nxt.sts = st_nxt.sts | ev;
    st_nxt.irq = |(st_nxt.sts & st_nxt.mask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r         <= '0;
      st_r.awready <= 1'b1;
      st_r.wready  <= 1'b1;
      st_r.arready <= 1'b1;
      for (int b = 0; b < 2; b++) begin
        st_r.bank[b].auto_en <= RST_AUTO_EN;
        st_r.bank[b].lazy_en <= RST_LAZY_EN;
      end
    end else begin
      st_r <= st_nxt;
    end
  end

  assign s_awready           = st_r.awready;
  assign s_wready            = st_r.wready;
  assign s_bvalid            = st_r.bvalid;
  assign s_bresp             = st_r.bresp;
  assign s_arready           = st_r.arready;
  assign s_rvalid            = st_r.rvalid;
  assign s_rdata             = st_r.rdata;
  assign s_rresp             = st_r.rresp;
  assign rf_rd_data          = st_r.rd_data;
  assign fp_status_control   = st_r.fp_stat;
  assign context_active_flag = st_r.ctx_act;
  assign save_pulse          = st_r.save;
  assign restore_pulse       = st_r.restore;
  assign clear_pulse         = st_r.clear;
  assign skip_mem            = st_r.skip;
  assign irq                 = st_r.irq;
endmodule : fpcc_ctrl

// [fpcc_ctrl_assertions.sv]
// Purpose: Port assertions for the fp context control block
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound onto every fpcc_ctrl instance
module fpcc_ctrl_assertions
  import fpcc_pkg::*;
(
  input wire logic                  aclk,
  input wire logic                  aresetn,
  input wire logic                  s_awvalid,
  input wire logic                  s_awready,
  input wire logic                  s_wvalid,
  input wire logic                  s_wready,
  input wire logic                  s_bvalid,
  input wire logic                  fp_instr_exec,
  input wire logic                  exc_entry,
  input wire fpcc_pkg::fpcc_alloc_t alloc_info,
  input wire logic                  exc_return,
  input wire logic                  ret_fp_frame,
  input wire logic [31:0]           fp_status_control,
  input wire logic                  context_active_flag,
  input wire logic                  save_pulse,
  input wire logic                  restore_pulse,
  input wire logic                  clear_pulse,
  input wire logic                  skip_mem
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  AST_CTX_CAUSE: assert property ($rose(context_active_flag) |->
    $past(fp_instr_exec || (exc_return && ret_fp_frame)))
    else $error("Active flag rose without cause");
  AST_ENTRY_CLR: assert property (exc_entry && !fp_instr_exec
    |=> !context_active_flag) else $error("Entry left flag set");
  AST_RESTORE: assert property (restore_pulse |->
    $past(exc_return && ret_fp_frame)) else $error("Stray restore");
  AST_SAVE: assert property (save_pulse |->
    $past(exc_entry || fp_instr_exec) && !skip_mem)
    else $error("Stray or skipped save");
  AST_CLR_CAUSE: assert property (clear_pulse |->
    $past(exc_return && context_active_flag)) else $error("Stray clear");
  AST_CLR_ZERO: assert property (clear_pulse |->
    fp_status_control == ZERO32) else $error("Status not cleared");
  AST_SKIP_CAP: assert property (exc_entry && context_active_flag
    |=> skip_mem == $past(alloc_info.splim))
    else $error("Violation not captured");
  AST_WR_LAT: assert property (s_awvalid && s_awready && s_wvalid
    && s_wready |-> ##2 s_bvalid) else $error("Late write response");
endmodule : fpcc_ctrl_assertions

bind fpcc_ctrl fpcc_ctrl_assertions u_chk (.aclk, .aresetn, .s_awvalid,
  .s_awready, .s_wvalid, .s_wready, .s_bvalid, .fp_instr_exec, .exc_entry,
  .alloc_info, .exc_return, .ret_fp_frame, .fp_status_control,
  .context_active_flag, .save_pulse, .restore_pulse, .clear_pulse,
  .skip_mem);

// [fpcc_ctrl_bench.sv]
// Purpose: Self-checking bench for the fp context control block
// Assumes: Secure core, Non-secure for the last check; model drives exception pulses
// Notes:   Fixed random seed
module fp_context_control_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import fpcc_pkg::*;
  logic        aclk, aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid;
  logic        s_rready, cur_secure, s_awready, s_wready, s_bvalid;
  logic        s_arready, s_rvalid, context_active_flag, save_pulse;
  logic        restore_pulse, clear_pulse, skip_mem, irq, fp_instr_exec;
  logic        exc_entry, exc_return, ret_fp_frame;
  logic [1:0]  s_bresp, s_rresp, op, rsp;
  logic [2:0]  s_awprot, s_arprot;
  logic [3:0]  s_awaddr, s_araddr, s_wstrb;
  logic [31:0] s_wdata, s_rdata, fp_status_control, d, v;
  logic [63:0] rf_rd_data, q, w;
  fpcc_alloc_t alloc, alloc_info, al;
  fpcc_rf_req_t rf_req;
  int          num_errors, total_checks, cyc, n_sv, n_rs, n_cl, seed, s;

  fpcc_ctrl uut (.aclk, .aresetn, .s_awaddr, .s_awprot, .s_awvalid,
    .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp,
    .s_bvalid, .s_bready, .s_araddr, .s_arprot, .s_arvalid, .s_arready,
    .s_rdata, .s_rresp, .s_rvalid, .s_rready, .fp_instr_exec, .cur_secure,
    .exc_entry, .alloc_info, .exc_return, .ret_fp_frame, .rf_req,
    .rf_rd_data, .fp_status_control, .context_active_flag, .save_pulse,
    .restore_pulse, .clear_pulse, .skip_mem, .irq);
  fpcc_proc_model pm (.aclk, .op, .alloc_in(alloc), .context_active_flag,
    .alloc_info, .fp_instr_exec, .exc_entry, .exc_return, .ret_fp_frame);

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (save_pulse) n_sv <= n_sv + 1;
    if (restore_pulse) n_rs <= n_rs + 1;
    if (clear_pulse) n_cl <= n_cl + 1;
    if (cyc == 20000) begin
      num_errors++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] x,
                    input logic ns);
    {s_awaddr, s_awprot, s_wdata} <= {a, 1'b0, ns, 1'b0, x};
    {s_awvalid, s_wvalid, s_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
    end while (!s_bvalid);
    rsp = s_bresp;
    s_bready <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic ns);
    {s_araddr, s_arprot} <= {a, 1'b0, ns, 1'b0};
    {s_arvalid, s_rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (s_arready) s_arvalid <= 1'b0;
    end while (!s_rvalid);
    s_rready <= 1'b0;
    d = s_rdata;
    rsp = s_rresp;
    @(posedge aclk);
  endtask : rd
  task automatic pr(input logic [1:0] o);
    op <= o;
    @(posedge aclk);
    op <= 2'h0;
    repeat (3) @(posedge aclk);
  endtask : pr
  task automatic rf(input logic [4:0] i, input logic b,
                    input logic [63:0] x, input logic we);
    rf_req <= '{we, b, i, x, b, i};
    @(posedge aclk);
    rf_req.wr_en <= 1'b0;
    repeat (2) @(posedge aclk);
    q = rf_rd_data;
  endtask : rf
  function automatic logic [31:0] ectl(input logic [31:0] t,
                                       input fpcc_alloc_t a);
    return t | {21'h0, a.uf_rdy, a.splim, 2'h0, a.bf_rdy, 2'h0, a.thread,
                3'h1};
  endfunction : ectl

  initial begin
    {aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
    {s_awaddr, s_araddr, s_awprot, s_arprot, s_wdata, op} = '0;
    {num_errors, total_checks, cyc, n_sv, n_rs, n_cl} = '0;
    rf_req = '0;
    alloc = 5'h01;
    {cur_secure, s_wstrb, seed} = {1'b1, 4'hF, 32'h0000_06C9};
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(OFS_CTRL, 1'b0);
    chk(d, 32'hC000_0000);
    wr(OFS_CTRL, 32'hC000_0000 | ($random(seed) & 32'h03FF_F800), 1'b0);
    rd(OFS_CTRL, 1'b0);
    chk(d, 32'hC000_0000);
    rd(4'hC, 1'b0);
    chk({rsp, d}, {RESP_ERR, ZERO32});
    wr(4'hC, ZERO32, 1'b0);
    chk(rsp, RESP_ERR);
    wr(OFS_CTRL, 32'h9000_0000, 1'b0);
    chk(rsp, RESP_OK);
    v = $random(seed);
    rf(5'h1F, 1'b0, {32'h0, v}, 1'b1);
    chk(q, {32'h0, v});
    w = {$random(seed), $random(seed)};
    rf(5'h0F, 1'b1, w, 1'b1);
    chk(q, w);
    rf(5'h03, 1'b0, {32'h0, v | 32'h0000_0001}, 1'b1);
    pr(2'h1);
    chk(context_active_flag, 1'b1);
    pr(2'h2);
    chk({n_sv, 31'h0, context_active_flag}, 64'h1_0000_0000);
    pr(2'h1);
    pr(2'h3);
    chk({n_rs, n_cl}, {32'h1, 32'h1});
    chk(fp_status_control, ZERO32);
    rf(5'h03, 1'b0, '0, 1'b0);
    chk(q, '0);
    for (int i = 0; i < 2; i++) begin
      wr(OFS_CTRL, 32'hC000_0000, 1'b0);
      pr(2'h1);
      al = 5'($random(seed));
      al.splim = i[0];
      al.secure = 1'b1;
      alloc <= al;
      pr(2'h2);
      rd(OFS_CTRL, 1'b0);
      chk(d, ectl(32'hC000_0000, al));
      s = n_sv;
      pr(2'h1);
      chk(n_sv, s + 1 - i);
      chk(skip_mem, i[0]);
      rd(OFS_CTRL, 1'b0);
      chk(d[0], 1'b0);
    end
    rd(OFS_STS, 1'b0);
    chk({irq, d[EV_SPLIM]}, 2'h1);
    wr(OFS_MASK, 32'h0000_0001, 1'b0);
    chk(irq, 1'b1);
    wr(OFS_STS, 32'h0000_0001, 1'b0);
    chk(irq, 1'b0);
    wr(OFS_CTRL, ZERO32, 1'b0);
    pr(2'h2);
    pr(2'h1);
    chk(context_active_flag, 1'b0);
    wr(OFS_CTRL, 32'h6000_0000, 1'b0);
    wr(OFS_CTRL, ZERO32, 1'b1);
    rd(OFS_CTRL, 1'b1);
    chk(d[30], 1'b1);
    rd(OFS_CTRL, 1'b0);
    chk(d[31:26], 6'h18);
    wr(OFS_CTRL, ZERO32, 1'b0);
    wr(OFS_CTRL, ZERO32, 1'b1);
    rd(OFS_CTRL, 1'b1);
    chk(d[30], 1'b0);
    cur_secure <= 1'b0;
    wr(OFS_CTRL, 32'h8000_0000, 1'b1);
    pr(2'h1);
    chk(context_active_flag, 1'b1);
    give_verdict();
  end
endmodule : fp_context_control_bench

// [fpcc_pkg.sv]
// Purpose: Shared constants and types for the fp context control block
// Assumes: AXI4-Lite with 32-bit data, word aligned registers
// Notes:   Bank index 1 is Secure, 0 is Non-secure
package fpcc_pkg;
  localparam logic [3:0]  OFS_CTRL   = 4'h0;
  localparam logic [3:0]  OFS_STS    = 4'h4;
  localparam logic [3:0]  OFS_MASK   = 4'h8;
  localparam int          B_AUTO_EN  = 31;
  localparam int          B_LAZY_EN  = 30;
  localparam int          B_LSLOCK   = 29;
  localparam int          B_CLRRET   = 28;
  localparam int          B_CLRLOCK  = 27;
  localparam int          B_TSEC     = 26;
  localparam int          B_UF_RDY   = 10;
  localparam int          B_SPLIM    = 9;
  localparam int          B_BF_RDY   = 6;
  localparam int          B_THREAD   = 3;
  localparam int          B_LZ_ACT   = 0;
  localparam logic        RST_AUTO_EN = 1'b1;
  localparam logic        RST_LAZY_EN = 1'b1;
  localparam logic [1:0]  RESP_OK    = 2'b00;
  localparam logic [1:0]  RESP_ERR   = 2'b10;
  localparam int          EV_SPLIM   = 0;
  localparam int          EV_CLR     = 1;
  localparam int          NEV        = 2;
  localparam logic [31:0] ZERO32     = 32'h0000_0000;

  typedef struct packed {
    logic auto_en;
    logic lazy_en;
    logic lazy_lock;
    logic clr_ret;
    logic clr_lock;
    logic tsec;
    logic uf_rdy;
    logic splim;
    logic bf_rdy;
    logic thread;
    logic lazy_act;
  } fpcc_bank_t;

  typedef struct packed {
    logic       uf_rdy;
    logic       bf_rdy;
    logic       thread;
    logic       splim;
    logic       secure;
  } fpcc_alloc_t;

  typedef struct packed {
    logic       wr_en;
    logic       wr_dbl;
    logic [4:0] wr_idx;
    logic [63:0] wr_data;
    logic       rd_dbl;
    logic [4:0] rd_idx;
  } fpcc_rf_req_t;
endpackage : fpcc_pkg

// [fpcc_proc_model.sv]
// Purpose: Exception entry and return side of the core
// Assumes: op 1 fp instr, 2 entry, 3 return; one pulse each
// Notes:   One-deep frame stack
module fpcc_proc_model
  import fpcc_pkg::*;
(
  input  wire logic                  aclk,
  input  wire logic [1:0]            op,
  input  wire fpcc_pkg::fpcc_alloc_t alloc_in,
  input  wire logic                  context_active_flag,
  output fpcc_pkg::fpcc_alloc_t      alloc_info,
  output logic                       fp_instr_exec,
  output logic                       exc_entry,
  output logic                       exc_return,
  output logic                       ret_fp_frame
);
  timeunit 1ns;
  timeprecision 1ns;
  logic frame_fp_r;
  initial begin
    {fp_instr_exec, exc_entry, exc_return, ret_fp_frame} = 4'h0;
    alloc_info = '0;
    frame_fp_r = 1'b0;
  end
  // Frame carries fp context if flag set at entry
  always @(posedge aclk) begin
    fp_instr_exec <= (op == 2'h1);
    exc_entry     <= (op == 2'h2);
    exc_return    <= (op == 2'h3);
    alloc_info    <= (op == 2'h2) ? alloc_in : ~alloc_in;
    if (op == 2'h2) frame_fp_r <= context_active_flag;
    ret_fp_frame  <= (op == 2'h3) ? frame_fp_r : !frame_fp_r;
  end
endmodule : fpcc_proc_model
